// ---- common/fcsr_defines.vh ----
`ifndef FCSR_DEFINES_VH
`define FCSR_DEFINES_VH
// command codes
`define FCSR_CMD_WRITE_REG 8'h01
`define FCSR_CMD_ST1_RD    8'h05
`define FCSR_CMD_SUSP_RD   8'h07
`define FCSR_CMD_BOOT_RD   8'h14
`define FCSR_CMD_BOOT_WR   8'h15
`define FCSR_CMD_BANK_RD   8'h16
`define FCSR_CMD_BANK_WR   8'h17
`define FCSR_CMD_ECC_RD    8'h18
`define FCSR_CMD_CLR_ST    8'h30
`define FCSR_CMD_CFG_RD    8'h35
`define FCSR_CMD_BANK_ACC  8'hb9
// status_one field positions
`define FCSR_ST1_ERR       6
`define FCSR_ST1_BP_HI     4
`define FCSR_ST1_BP_LO     2
// config_one field positions
`define FCSR_CFG_VOL       3
`define FCSR_CFG_PTOP      2
`define FCSR_CFG_QUAD      1
`define FCSR_CFG_FRZ       0
// suspend_status field positions
`define FCSR_SUS_ERASE     1
`define FCSR_SUS_PROG      0
// bank_address field positions
`define FCSR_BANK_FOUR     7
`define FCSR_BANK_HIGH     1
// correction_status width of defined bits
`define FCSR_ECC_BITS      3
// reset values
`define FCSR_BP_FACTORY    3'h0
`define FCSR_BP_VOL_RST    3'h7
`define FCSR_QUAD_RST      1'b1
`define FCSR_BOOT_RST      32'h00000000
// boot_at_reset field positions
`define FCSR_BOOT_ADDR_LO  9
`define FCSR_BOOT_DLY_HI   8
`define FCSR_BOOT_DLY_LO   1
`define FCSR_BOOT_EN       0
// set to 1'b1 for the 1 Gb density build
`define FCSR_DENSITY_1GB   1'b0
// byte counts
`define FCSR_BOOT_BYTES    3'h4
`define FCSR_ADDR3_BYTES   3'h3
`define FCSR_ADDR4_BYTES   3'h4
`endif

// ---- rtl/fcsr_regs.v ----
// Notes on behaviour
// - protect-volatility 0 keeps protect levels; 1 makes them reset to 111.
// - factory state: volatility 0, protect levels 000.
// - volatility is set-only; clearing attempt fails and sets program error.
// - param-sector bit places small sectors at top when 1, bottom when 0.
// - param-sector bit ships 0, set-only; clearing attempt with freeze 0 sets program error.
// - wide-data bit selects 4-bit data width; factory value 1.
// - freeze locks protect levels, param-sector bit and otp space.
// - with freeze 0 all config bits including freeze are writable.
// - freeze is volatile, 0 at power-on, cleared only by power or hardware reset.
// - freeze may be set by the same register write as other config bits.
// - suspend bit 1 shows erase suspended; read-only.
// - suspend bit 0 shows program suspended; read with 07h.
// - boot enable starts boot read after any reset; read 14h, write 15h.
// - boot register bits 31..9 hold the 512-byte aligned start address.
// - boot register bits 8..1 hold start delay cycles, default 00h.
// - three-byte addresses take bank bits above A23 unless four-byte mode.
// - four-byte bit is volatile, cleared by every reset.
// - bank register reached by b9h, 16h, 17h and the register write.
// - 18h plus unit address returns that unit's 8-bit correction status.
// - status bits: 2 check-code error, 1 data corrected, 0 correction off.
`include "fcsr_defines.vh"
module fcsr_regs
(
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire        i_hw_rst_n,
  input  wire        i_soft_reset,
  input  wire        i_sck,
  input  wire        i_cs_n,
  input  wire        i_si,
  input  wire        i_erase_suspended,
  input  wire        i_program_suspended,
  input  wire [2:0]  i_ecc_status,
  output reg         o_so,
  output reg         o_so_oe,
  output reg  [2:0]  o_block_protect_level,
  output reg         o_protect_volatility_select,
  output reg         o_param_sector_top_select,
  output reg         o_quad_mode,
  output reg         o_freeze,
  output reg         o_four_byte_addr_enable,
  output reg  [7:0]  o_bank_bits,
  output reg         o_program_error,
  output reg  [31:0] o_ecc_addr,
  output reg         o_boot_start,
  output reg  [31:0] o_boot_addr,
  output reg  [7:0]  o_boot_delay,
  output reg         o_boot_auto_enable
);
  localparam ST_CMD  = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_IGN  = 3'h4;

  reg  [1:0]  sck_s;
  reg  [1:0]  cs_s;
  reg  [1:0]  si_s;
  reg  [1:0]  hw_s;
  reg         sck_d;
  reg         hw_d;
  reg         por_done;
  reg  [2:0]  st;
  reg  [2:0]  bit_cnt;
  reg  [2:0]  byte_idx;
  reg  [6:0]  in_sh;
  reg  [7:0]  cmd;
  reg  [7:0]  tx_sh;
  reg  [23:0] addr_sh;
  reg  [23:0] boot_sh;
  reg  [31:0] boot_reg;
  reg         bank_acc;
  reg         bank_high_bit;
  reg         ecc_pend;
  reg         ecc_done;
  reg  [2:0]  ecc_stat;

  wire        sck_q   = sck_s[1];
  wire        cs_n_q  = cs_s[1];
  wire        si_q    = si_s[1];
  wire        hw_act  = ~hw_s[1];
  wire        sck_ris = sck_q & ~sck_d & ~cs_n_q;
  wire        sck_fal = ~sck_q & sck_d & ~cs_n_q;
  wire        done    = sck_ris & (bit_cnt == 3'h7);
  wire [7:0]  rx      = {in_sh, si_q};
  wire        rst_evt = hw_act | i_soft_reset;
  wire [2:0]  addr_n  = o_four_byte_addr_enable ? `FCSR_ADDR4_BYTES : `FCSR_ADDR3_BYTES;

  // bank bits that extend a three-byte address
  function [7:0] bank_ext;
    input four;
    input high;
    begin
      bank_ext = four ? 8'h00 : {6'h00, high, 1'b0};
    end
  endfunction

  function [7:0] bank_reg;
    input four;
    input high;
    begin
      bank_reg = {four, 5'h00, high, 1'b0};
    end
  endfunction

  function [7:0] rd_byte;
    input [7:0] c;
    input [2:0] idx;
    begin
      case (c)
        `FCSR_CMD_SUSP_RD:
          rd_byte = {6'h00, i_erase_suspended, i_program_suspended};
        `FCSR_CMD_BOOT_RD:
          case (idx)
            3'h1:    rd_byte = boot_reg[31:24];
            3'h2:    rd_byte = boot_reg[23:16];
            3'h3:    rd_byte = boot_reg[15:8];
            default: rd_byte = boot_reg[7:0];
          endcase
        `FCSR_CMD_BANK_RD:
          rd_byte = bank_reg(o_four_byte_addr_enable, bank_high_bit);
        `FCSR_CMD_ST1_RD:
          rd_byte = {1'b0, o_program_error, 1'b0, o_block_protect_level, 2'h0};
        `FCSR_CMD_CFG_RD:
          rd_byte = {4'h0, o_protect_volatility_select, o_param_sector_top_select,
                     o_quad_mode, o_freeze};
        `FCSR_CMD_ECC_RD:
          rd_byte = {5'h00, ecc_stat};
        default:
          rd_byte = 8'h00;
      endcase
    end
  endfunction

  function is_read;
    input [7:0] c;
    begin
      is_read = (c == `FCSR_CMD_SUSP_RD) | (c == `FCSR_CMD_BOOT_RD) |
                (c == `FCSR_CMD_BANK_RD) | (c == `FCSR_CMD_ST1_RD) |
                (c == `FCSR_CMD_CFG_RD) | (c == `FCSR_CMD_ECC_RD);
    end
  endfunction

  // pins are asynchronous to the reference clock
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sck_s <= 2'h0;
      cs_s  <= 2'h3;
      si_s  <= 2'h0;
      hw_s  <= 2'h3;
      sck_d <= 1'b0;
      hw_d  <= 1'b0;
    end
    else
    begin
      sck_s <= {sck_s[0], i_sck};
      cs_s  <= {cs_s[0], i_cs_n};
      si_s  <= {si_s[0], i_si};
      hw_s  <= {hw_s[0], i_hw_rst_n};
      sck_d <= sck_q;
      hw_d  <= hw_act;
    end
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st                          <= ST_CMD;
      bit_cnt                     <= 3'h0;
      byte_idx                    <= 3'h0;
      in_sh                       <= 7'h00;
      cmd                         <= 8'h00;
      tx_sh                       <= 8'h00;
      addr_sh                     <= 24'h000000;
      boot_sh                     <= 24'h000000;
      boot_reg                    <= `FCSR_BOOT_RST;
      bank_acc                    <= 1'b0;
      bank_high_bit               <= 1'b0;
      ecc_pend                    <= 1'b0;
      ecc_done                    <= 1'b0;
      ecc_stat                    <= 3'h0;
      por_done                    <= 1'b0;
      o_so                        <= 1'b0;
      o_so_oe                     <= 1'b0;
      o_block_protect_level       <= `FCSR_BP_FACTORY;
      o_protect_volatility_select <= 1'b0;
      o_param_sector_top_select   <= 1'b0;
      o_quad_mode                 <= `FCSR_QUAD_RST;
      o_freeze                    <= 1'b0;
      o_four_byte_addr_enable     <= 1'b0;
      o_bank_bits                 <= 8'h00;
      o_program_error             <= 1'b0;
      o_ecc_addr                  <= 32'h00000000;
      o_boot_start                <= 1'b0;
      o_boot_addr                 <= 32'h00000000;
      o_boot_delay                <= 8'h00;
      o_boot_auto_enable          <= 1'b0;
    end
    else
    begin
      por_done           <= 1'b1;
      // boot read starts as each reset completes
      o_boot_start       <= boot_reg[`FCSR_BOOT_EN] &
                            (~por_done | (hw_d & ~hw_act) | i_soft_reset);
      o_boot_addr        <= {boot_reg[31:`FCSR_BOOT_ADDR_LO], 9'h000};
      o_boot_delay       <= boot_reg[`FCSR_BOOT_DLY_HI:`FCSR_BOOT_DLY_LO];
      o_boot_auto_enable <= boot_reg[`FCSR_BOOT_EN];
      o_bank_bits        <= bank_ext(o_four_byte_addr_enable, bank_high_bit);
      if (rst_evt)
      begin
        st                      <= ST_CMD;
        bit_cnt                 <= 3'h0;
        byte_idx                <= 3'h0;
        bank_acc                <= 1'b0;
        ecc_pend                <= 1'b0;
        o_so_oe                 <= 1'b0;
        o_four_byte_addr_enable <= 1'b0;
        bank_high_bit           <= 1'b0;
        if (o_protect_volatility_select)
          o_block_protect_level <= `FCSR_BP_VOL_RST;
        if (hw_act)
          o_freeze <= 1'b0;
      end
      else if (cs_n_q)
      begin
        st       <= ST_CMD;
        bit_cnt  <= 3'h0;
        byte_idx <= 3'h0;
        ecc_pend <= 1'b0;
        ecc_done <= 1'b0;
        o_so_oe  <= 1'b0;
      end
      else if (ecc_pend)
      begin
        // status fetched one cycle after the address settles
        ecc_pend <= 1'b0;
        ecc_stat <= i_ecc_status;
        tx_sh    <= {5'h00, i_ecc_status};
      end
      else if (sck_fal)
      begin
        o_so    <= tx_sh[7];
        tx_sh   <= {tx_sh[6:0], 1'b0};
        o_so_oe <= st[1] & is_read(cmd) & (cmd != `FCSR_CMD_ECC_RD | ecc_done);
      end
      else if (sck_ris)
      begin
        bit_cnt <= bit_cnt + 3'h1;
        in_sh   <= {in_sh[5:0], si_q};
        if (done)
        begin
          case (st)
            ST_CMD:
            begin
              cmd      <= rx;
              st       <= ST_DATA;
              byte_idx <= 3'h1;
              tx_sh    <= rd_byte(rx, 3'h1);
              if (rx == `FCSR_CMD_BANK_ACC)
                bank_acc <= 1'b1;
              else if (rx != `FCSR_CMD_WRITE_REG)
                bank_acc <= 1'b0;
              if (rx == `FCSR_CMD_CLR_ST)
                o_program_error <= 1'b0;
            end
            ST_DATA:
            begin
              byte_idx <= (byte_idx == `FCSR_BOOT_BYTES) ? 3'h1 : byte_idx + 3'h1;
              tx_sh    <= rd_byte(cmd, (byte_idx == `FCSR_BOOT_BYTES) ? 3'h1 : byte_idx + 3'h1);
              case (cmd)
                `FCSR_CMD_WRITE_REG:
                begin
                  if (byte_idx == 3'h1 && bank_acc)
                  begin
                    bank_acc                <= 1'b0;
                    o_four_byte_addr_enable <= rx[`FCSR_BANK_FOUR];
                    bank_high_bit           <= rx[`FCSR_BANK_HIGH] & `FCSR_DENSITY_1GB;
                    st                      <= ST_IGN;
                  end
                  else if (byte_idx == 3'h1)
                  begin
                    if (!o_freeze)
                      o_block_protect_level <= rx[`FCSR_ST1_BP_HI:`FCSR_ST1_BP_LO];
                  end
                  else
                  begin
                    st <= ST_IGN;
                    if (rx[`FCSR_CFG_VOL])
                      o_protect_volatility_select <= 1'b1;
                    else if (o_protect_volatility_select)
                      o_program_error <= 1'b1;
                    if (!o_freeze)
                    begin
                      if (rx[`FCSR_CFG_PTOP])
                        o_param_sector_top_select <= 1'b1;
                      else if (o_param_sector_top_select)
                        o_program_error <= 1'b1;
                    end
                    o_quad_mode <= rx[`FCSR_CFG_QUAD];
                    o_freeze    <= o_freeze | rx[`FCSR_CFG_FRZ];
                  end
                end
                `FCSR_CMD_BANK_WR:
                begin
                  st                      <= ST_IGN;
                  o_four_byte_addr_enable <= rx[`FCSR_BANK_FOUR];
                  bank_high_bit           <= rx[`FCSR_BANK_HIGH] & `FCSR_DENSITY_1GB;
                end
                `FCSR_CMD_BOOT_WR:
                begin
                  boot_sh <= {boot_sh[15:0], rx};
                  if (byte_idx == `FCSR_BOOT_BYTES)
                  begin
                    st       <= ST_IGN;
                    boot_reg <= {boot_sh, rx};
                  end
                end
                `FCSR_CMD_ECC_RD:
                begin
                  addr_sh <= {addr_sh[15:0], rx};
                  if (!ecc_done && byte_idx == addr_n)
                  begin
                    ecc_done <= 1'b1;
                    ecc_pend <= 1'b1;
                    if (o_four_byte_addr_enable)
                      o_ecc_addr <= {addr_sh, rx};
                    else
                      o_ecc_addr <= {o_bank_bits, addr_sh[15:0], rx};
                  end
                end
                default:
                begin
                  // reads repeat; unknown commands fall through quietly
                  if (!is_read(cmd))
                    st <= ST_IGN;
                end
              endcase
            end
            ST_IGN:
              st <= ST_IGN;
            default:
              st <= ST_CMD;
          endcase
        end
      end
    end
  end
endmodule

// ---- tb/fcsr_regs_assertions.sv ----
module fcsr_regs_chk (
  input logic        i_ref_clk,
  input logic        i_rst,
  input logic        i_hw_rst_n,
  input logic        i_soft_reset,
  input logic [2:0]  o_block_protect_level,
  input logic        o_protect_volatility_select,
  input logic        o_param_sector_top_select,
  input logic        o_freeze,
  input logic        o_four_byte_addr_enable,
  input logic [7:0]  o_bank_bits,
  input logic        o_program_error,
  input logic        o_boot_start,
  input logic [31:0] o_boot_addr,
  input logic        o_boot_auto_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // the pin is synced, so four low samples before judging
  chk_hw_clears: assert property (!i_hw_rst_n [*4] |-> !o_freeze && !o_four_byte_addr_enable)
    else $error("hardware reset left freeze or four-byte set");
  chk_bp_volatile: assert property (!i_hw_rst_n [*4] ##0 o_protect_volatility_select |-> o_block_protect_level == 3'h7)
    else $error("volatile protect level not reset");
  chk_vol_sticky: assert property (o_protect_volatility_select |=> o_protect_volatility_select)
    else $error("volatility bit cleared");
  chk_ptop_sticky: assert property (o_param_sector_top_select |=> o_param_sector_top_select)
    else $error("param sector bit cleared");
  chk_err_cause: assert property ($rose(o_program_error) |-> o_protect_volatility_select || o_param_sector_top_select)
    else $error("program error without a set one-time bit");
  chk_soft_freeze: assert property (i_hw_rst_n [*3] ##0 (o_freeze && i_soft_reset) |=> o_freeze [*2])
    else $error("soft reset cleared freeze");
  // soft reset may still reload volatile levels, so it is left out
  chk_freeze_lock: assert property (o_freeze && $past(o_freeze) && !$past(i_soft_reset)
    && !$past(i_soft_reset, 2) |-> $stable(o_block_protect_level) && $stable(o_param_sector_top_select))
    else $error("locked field changed");
  chk_bank_four: assert property (o_four_byte_addr_enable |-> o_bank_bits == 8'h00)
    else $error("bank bits used in four-byte mode");
  chk_bank_resv: assert property (o_bank_bits[7:2] == 6'h00 && !o_bank_bits[0])
    else $error("reserved bank bit set");
  chk_boot_align: assert property (o_boot_addr[8:0] == 9'h000)
    else $error("boot address not aligned");
  chk_boot_cause: assert property (o_boot_start |-> o_boot_auto_enable)
    else $error("boot started while disabled");
  cover property (o_boot_start);
  cover property ($rose(o_freeze));
  cover property ($rose(o_program_error));
endmodule

bind fcsr_regs fcsr_regs_chk u_chk (.*);

// ---- tb/fcsr_host.sv ----
module fcsr_host (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input  logic i_so
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // mode 0, msb first; sck rests low outside frames
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    #330 o_cs_n = 1'b0;
    foreach (tx[i])
    begin
      for (int k = 7; k >= 0; k--)
      begin
        o_si = tx[i][k];
        #400 o_sck = 1'b1;
        b[k] = i_so;
        #400 o_sck = 1'b0;
      end
      rx.push_back(b);
    end
    #400 o_cs_n = 1'b1;
    // a released line must not keep its last level
    o_si = ~o_si;
    #700;
  endtask
endmodule

// ---- tb/fcsr_regs_test.sv ----
module fcsr_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_ref_clk, i_rst, i_hw_rst_n, i_soft_reset, i_erase_suspended, i_program_suspended;
  logic [2:0]  i_ecc_status;
  wire         i_sck, i_cs_n, i_si, o_so, o_so_oe, o_protect_volatility_select, o_param_sector_top_select;
  wire         o_quad_mode, o_freeze, o_four_byte_addr_enable, o_program_error, o_boot_start, o_boot_auto_enable;
  wire [2:0]   o_block_protect_level;
  wire [7:0]   o_bank_bits, o_boot_delay;
  wire [31:0]  o_ecc_addr, o_boot_addr;
  logic [7:0]  rx[$];
  int          fails, compares, cycles, boots;
  fcsr_regs dut (.*);
  // an undriven data line shows the inverse, so a missing enable cannot pass
  fcsr_host host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so_oe ? o_so : ~o_so));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (o_boot_start === 1'b1)
      boots++;
    if (cycles == 30000)
    begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic soft_reset(input int exp);
    int n;
    n = boots;
    @(posedge i_ref_clk) i_soft_reset <= 1'b1;
    @(posedge i_ref_clk) i_soft_reset <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk(boots - n, exp, "boot start count");
  endtask
  task automatic hw_reset(input int exp);
    int n;
    n = boots;
    @(posedge i_ref_clk) i_hw_rst_n <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_hw_rst_n <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk(boots - n, exp, "hw boot count");
  endtask
  task automatic t_factory();
    host.frame({8'h35, 8'h00}, rx);
    chk(rx[1], 8'h02, "config");
    chk(o_quad_mode, 1'b1, "quad");
    host.frame({8'h05, 8'h00}, rx);
    chk(rx[1], 8'h00, "status");
    host.frame({8'h16, 8'h00}, rx);
    chk(rx[1], 8'h00, "bank");
    host.frame({8'h14, 8'h00, 8'h00, 8'h00, 8'h00}, rx);
    chk({rx[1], rx[2], rx[3], rx[4]}, 32'h0, "boot");
    $display("done factory");
  endtask
  task automatic t_suspend();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_ref_clk) {i_erase_suspended, i_program_suspended} <= k[1:0];
      host.frame({8'h07, 8'h00}, rx);
      chk(rx[1], k, "suspend");
    end
    $display("done suspend");
  endtask
  task automatic t_ecc();
    for (int k = 0; k < 3; k++)
    begin
      @(posedge i_ref_clk) i_ecc_status <= 3'h1 << k;
      host.frame({8'h18, 8'h01, 8'h20, 8'(k * 16), 8'h00}, rx);
      chk(rx[4][2:0], 1 << k, "ecc status");
      chk(rx[4][7:3], 0, "ecc reserved");
      chk(o_ecc_addr[23:0], 24'h012000 + k * 16, "ecc unit");
    end
    $display("done ecc");
  endtask
  task automatic t_boot();
    host.frame({8'h15, 8'h00, 8'h02, 8'h0a, 8'h05}, rx);
    chk(o_boot_addr, 32'h00020a00, "boot addr");
    chk(o_boot_delay, 8'h02, "boot delay");
    chk(o_boot_auto_enable, 1'b1, "boot enable");
    host.frame({8'h14, 8'h00, 8'h00, 8'h00, 8'h00}, rx);
    chk({rx[1], rx[2], rx[3], rx[4]}, 32'h00020a05, "boot read");
    soft_reset(1);
    hw_reset(1);
    host.frame({8'h15, 8'h00, 8'h00, 8'h00, 8'h00}, rx);
    soft_reset(0);
    $display("done boot");
  endtask
  task automatic t_bank();
    host.frame({8'h17, 8'h82}, rx);
    chk(o_four_byte_addr_enable, 1'b1, "four-byte");
    chk(o_bank_bits, 8'h00, "bank bits");
    @(posedge i_ref_clk) i_ecc_status <= 3'h3;
    host.frame({8'h18, 8'h01, 8'h02, 8'h03, 8'h04, 8'h00}, rx);
    chk(o_ecc_addr, 32'h01020304, "four-byte unit");
    chk(rx[5], 8'h03, "four-byte status");
    host.frame({8'h16, 8'h00}, rx);
    chk(rx[1], 8'h80, "bank read");
    host.frame({8'hb9}, rx);
    host.frame({8'h01, 8'h00}, rx);
    chk(o_four_byte_addr_enable, 1'b0, "bank access");
    host.frame({8'h17, 8'h80}, rx);
    soft_reset(0);
    chk(o_four_byte_addr_enable, 1'b0, "four after reset");
    $display("done bank");
  endtask
  task automatic t_config();
    host.frame({8'h01, 8'h08, 8'h0e}, rx);
    chk({o_protect_volatility_select, o_param_sector_top_select, o_block_protect_level}, 5'h1a, "cfg");
    host.frame({8'h01, 8'h08, 8'h02}, rx);
    chk({o_protect_volatility_select, o_param_sector_top_select}, 2'h3, "otp kept");
    chk(o_program_error, 1'b1, "error");
    host.frame({8'h30}, rx);
    host.frame({8'h01, 8'h04, 8'h0f}, rx);
    chk({o_freeze, o_block_protect_level}, 4'h9, "freeze write");
    host.frame({8'h01, 8'h1c, 8'h0f}, rx);
    chk({o_program_error, o_block_protect_level}, 4'h1, "frozen");
    soft_reset(0);
    chk({o_freeze, o_block_protect_level}, 4'hf, "soft reset");
    hw_reset(0);
    chk({o_freeze, o_block_protect_level}, 4'h7, "hw reset");
    $display("done config");
  endtask
  initial
  begin
    i_rst = 1'b1;
    i_hw_rst_n = 1'b1;
    i_soft_reset = 1'b0;
    i_erase_suspended = 1'b0;
    i_program_suspended = 1'b0;
    i_ecc_status = 3'h0;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    t_factory();
    t_suspend();
    t_ecc();
    t_boot();
    t_bank();
    t_config();
    conclude();
  end
endmodule
